// ===== logic/tsp_pkg.sv
// tsp_pkg: constants shared by the timing signal pin multiplexer.
// Assumes the register port addresses byte-wide offsets with 16-bit data.
`default_nettype none
package tsp_pkg;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int SEL_W    = 5;
  localparam int NUM_PINS = 2;

  // register offsets
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h02;
  localparam logic [7:0] ADDR_SRC_SEL  = 8'h0B;
  localparam logic [7:0] ADDR_PIN1_EN  = 8'h4F;

  // field positions
  localparam int CTRL_POL0_BIT = 0;
  localparam int CTRL_OD0_BIT  = 1;
  localparam int CTRL_EN0_BIT  = 2;
  localparam int CTRL_POL1_BIT = 8;
  localparam int CTRL_OD1_BIT  = 9;
  localparam int PIN1_EN_BIT   = 6;
  localparam int SEL0_LSB      = 0;
  localparam int SEL1_LSB      = 8;

  // values after reset
  localparam logic [15:0] RST_PIN_CTRL = 16'h0000;
  localparam logic [15:0] RST_SRC_SEL  = 16'h0000;
  localparam logic        RST_PIN1_EN  = 1'b0;

  // source select codes
  localparam logic [4:0] SRC_IRQ      = 5'h01;
  localparam logic [4:0] SRC_WINDOW   = 5'h02;
  localparam logic [4:0] SRC_LED_A    = 5'h05;
  localparam logic [4:0] SRC_LED_B    = 5'h06;
  localparam logic [4:0] SRC_LED_AB   = 5'h07;
  localparam logic [4:0] SRC_WR_A     = 5'h0C;
  localparam logic [4:0] SRC_WR_B     = 5'h0D;
  localparam logic [4:0] SRC_WR_AB    = 5'h0E;
  localparam logic [4:0] SRC_HALF     = 5'h0F;
  localparam logic [4:0] SRC_LOW      = 5'h10;
  localparam logic [4:0] SRC_HIGH     = 5'h11;
  localparam logic [4:0] SRC_OSC      = 5'h13;

  typedef enum logic [1:0] {
    WIN_IDLE = 2'b01,
    WIN_OPEN = 2'b10
  } tsp_win_t;
endpackage
`default_nettype wire

// ===== logic/tsp_pin_if.sv
// tsp_pin_if: per-pin configuration and asserted levels between the
// register file, the source multiplexer and the pin drivers.
// Assumes one clock domain shared by all users.
`timescale 1ns/100ps
`default_nettype none
interface tsp_pin_if;
  logic [tsp_pkg::NUM_PINS-1:0]                     pol;
  logic [tsp_pkg::NUM_PINS-1:0]                     od;
  logic [tsp_pkg::NUM_PINS-1:0]                     en;
  logic [tsp_pkg::NUM_PINS-1:0][tsp_pkg::SEL_W-1:0] sel;
  logic [tsp_pkg::NUM_PINS-1:0]                     asserted;

  modport regs (output pol, od, en, sel);
  modport mux  (input sel, output asserted);
  modport drv  (input pol, od, en, asserted);
endinterface
`default_nettype wire

// ===== logic/tsp_reg_file.sv
// tsp_reg_file: holds pin control, source select and pin-one enable.
// Assumes a one-cycle write strobe with address and data valid alongside.
`timescale 1ns/100ps
`default_nettype none
module tsp_reg_file (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       wr_in,
  input  wire logic [tsp_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [tsp_pkg::DATA_W-1:0] wdata_in,
  tsp_pin_if.regs                         pif
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pif.pol[0] <= tsp_pkg::RST_PIN_CTRL[tsp_pkg::CTRL_POL0_BIT];
      pif.od[0]  <= tsp_pkg::RST_PIN_CTRL[tsp_pkg::CTRL_OD0_BIT];
      pif.en[0]  <= tsp_pkg::RST_PIN_CTRL[tsp_pkg::CTRL_EN0_BIT];
      pif.pol[1] <= tsp_pkg::RST_PIN_CTRL[tsp_pkg::CTRL_POL1_BIT];
      pif.od[1]  <= tsp_pkg::RST_PIN_CTRL[tsp_pkg::CTRL_OD1_BIT];
    end else if (wr_in && addr_in == tsp_pkg::ADDR_PIN_CTRL) begin
      pif.pol[0] <= wdata_in[tsp_pkg::CTRL_POL0_BIT];
      pif.od[0]  <= wdata_in[tsp_pkg::CTRL_OD0_BIT];
      pif.en[0]  <= wdata_in[tsp_pkg::CTRL_EN0_BIT];
      pif.pol[1] <= wdata_in[tsp_pkg::CTRL_POL1_BIT];
      pif.od[1]  <= wdata_in[tsp_pkg::CTRL_OD1_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pif.en[1] <= tsp_pkg::RST_PIN1_EN;
    end else if (wr_in && addr_in == tsp_pkg::ADDR_PIN1_EN) begin
      pif.en[1] <= wdata_in[tsp_pkg::PIN1_EN_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pif.sel[0] <= tsp_pkg::RST_SRC_SEL[tsp_pkg::SEL0_LSB +: tsp_pkg::SEL_W];
      pif.sel[1] <= tsp_pkg::RST_SRC_SEL[tsp_pkg::SEL1_LSB +: tsp_pkg::SEL_W];
    end else if (wr_in && addr_in == tsp_pkg::ADDR_SRC_SEL) begin
      pif.sel[0] <= wdata_in[tsp_pkg::SEL0_LSB +: tsp_pkg::SEL_W];
      pif.sel[1] <= wdata_in[tsp_pkg::SEL1_LSB +: tsp_pkg::SEL_W];
    end
  end
endmodule // tsp_reg_file
`default_nettype wire

// ===== logic/tsp_pin_drv.sv
// tsp_pin_drv: turns one pin's asserted level into a registered level
// and active-low output enable. Assumes the pad combines them.
`timescale 1ns/100ps
`default_nettype none
module tsp_pin_drv #(
  parameter int PIN = 0
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  tsp_pin_if.drv    pif,
  output var  logic pin_out,
  output var  logic oe_n_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= pif.asserted[PIN] ^ pif.pol[PIN];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_n_out <= 1'b1;
    end else begin
      // open drain releases the pin whenever the signal is not asserted
      oe_n_out <= ~(pif.en[PIN] & (~pif.od[PIN] | pif.asserted[PIN]));
    end
  end
endmodule // tsp_pin_drv
`default_nettype wire

// ===== logic/tsp_timing_pin_mux.sv
// tsp_timing_pin_mux: routes internal timing signals onto two timing pins.
// Assumes all timing-engine inputs are synchronous one-cycle pulses or
// levels on CLOCK_IN, and the register port is a simple strobe port.
//
// Function
// - polarity bit per pin, 1 means active low
// - drive-mode bit: always drive or open drain
// - pin zero drives only with control bit 2
// - pin one drives only with config bit 6
// - five-bit source select field per pin
// - select register zero gives legacy pin behaviour
// - code 0x01 routes interrupt level
// - code 0x02 gives enabled-slot sample window
// - codes 0x05-0x07 copy LED pulses
// - codes 0x0C-0x0E flag slot data written
// - written flag sets on data write, clears on sample start
// - code 0x0F toggles once per sample
// - toggle starts low leaving standby
// - code 0x10 holds constant low
// - code 0x11 holds constant high
// - code 0x13 copies 32 kHz oscillator
`timescale 1ns/100ps
`default_nettype none
module tsp_timing_pin_mux (
  input  wire logic                       CLOCK_IN,
  input  wire logic                       RESET_IN,
  // register port
  input  wire logic                       REG_WR_IN,
  input  wire logic                       REG_RD_IN,
  input  wire logic [tsp_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [tsp_pkg::DATA_W-1:0] REG_WDATA_IN,
  output var  logic [tsp_pkg::DATA_W-1:0] REG_RDATA_OUT,
  output var  logic                       REG_RVALID_OUT,
  // timing engine
  input  wire logic                       IRQ_LEVEL_IN,
  input  wire logic                       NORMAL_MODE_IN,
  input  wire logic                       SLOT_A_EN_IN,
  input  wire logic                       SLOT_B_EN_IN,
  input  wire logic                       SLOT_A_START_IN,
  input  wire logic                       SLOT_A_END_IN,
  input  wire logic                       SLOT_B_START_IN,
  input  wire logic                       SLOT_B_END_IN,
  input  wire logic                       SAMPLE_START_IN,
  input  wire logic                       DATA_A_WRITTEN_IN,
  input  wire logic                       DATA_B_WRITTEN_IN,
  input  wire logic                       LED_A_PULSE_IN,
  input  wire logic                       LED_B_PULSE_IN,
  input  wire logic                       OSC_32K_IN,
  // timing pins
  output var  logic                       TIMING_PIN_ZERO_OUT,
  output var  logic                       TIMING_PIN_ZERO_OE_N_OUT,
  output var  logic                       TIMING_PIN_ONE_OUT,
  output var  logic                       TIMING_PIN_ONE_OE_N_OUT
);

  tsp_pin_if pif ();

  tsp_pkg::tsp_win_t              win_state_reg;
  tsp_pkg::tsp_win_t              win_state_next;
  logic                           win_open;
  logic                           win_close;
  logic                           window_level;
  logic                           mode_prev_reg;
  logic                           standby_exit;
  logic                           half_rate_toggle_reg;
  logic                           wr_a_reg;
  logic                           wr_b_reg;
  logic                           legacy_mode;
  logic                           legacy_sample_output;
  logic [tsp_pkg::NUM_PINS-1:0]   pin_level;
  logic [tsp_pkg::NUM_PINS-1:0]   pin_oe_n;
  logic [tsp_pkg::DATA_W-1:0]     rdata_next;

  // register storage

  tsp_reg_file u_regs (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .wr_in    (REG_WR_IN),
    .addr_in  (REG_ADDR_IN),
    .wdata_in (REG_WDATA_IN),
    .pif      (pif.regs)
  );

  // read back: one cycle after the read strobe, unmapped reads zero

  always_comb begin
    rdata_next = '0;
    case (REG_ADDR_IN)
      tsp_pkg::ADDR_PIN_CTRL: begin
        rdata_next[tsp_pkg::CTRL_POL0_BIT] = pif.pol[0];
        rdata_next[tsp_pkg::CTRL_OD0_BIT]  = pif.od[0];
        rdata_next[tsp_pkg::CTRL_EN0_BIT]  = pif.en[0];
        rdata_next[tsp_pkg::CTRL_POL1_BIT] = pif.pol[1];
        rdata_next[tsp_pkg::CTRL_OD1_BIT]  = pif.od[1];
      end
      tsp_pkg::ADDR_SRC_SEL: begin
        rdata_next[tsp_pkg::SEL0_LSB +: tsp_pkg::SEL_W] = pif.sel[0];
        rdata_next[tsp_pkg::SEL1_LSB +: tsp_pkg::SEL_W] = pif.sel[1];
      end
      tsp_pkg::ADDR_PIN1_EN: begin
        rdata_next[tsp_pkg::PIN1_EN_BIT] = pif.en[1];
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= '0;
    end else if (REG_RD_IN) begin
      REG_RDATA_OUT <= rdata_next;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
    end
  end

  // sample window: first enabled slot start to last enabled slot end

  always_comb begin
    win_open  = (SLOT_A_START_IN & SLOT_A_EN_IN) |
                (SLOT_B_START_IN & SLOT_B_EN_IN & ~SLOT_A_EN_IN);
    win_close = (SLOT_B_END_IN & SLOT_B_EN_IN) |
                (SLOT_A_END_IN & SLOT_A_EN_IN & ~SLOT_B_EN_IN);
  end

  always_comb begin
    win_state_next = win_state_reg;
    case (win_state_reg)
      tsp_pkg::WIN_IDLE: begin
        if (win_open) begin
          win_state_next = tsp_pkg::WIN_OPEN;
        end
      end
      tsp_pkg::WIN_OPEN: begin
        if (win_close) begin
          win_state_next = tsp_pkg::WIN_IDLE;
        end
      end
      default: begin
        win_state_next = tsp_pkg::WIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      win_state_reg <= tsp_pkg::WIN_IDLE;
    end else begin
      win_state_reg <= win_state_next;
    end
  end

  assign window_level         = (win_state_reg == tsp_pkg::WIN_OPEN);
  assign legacy_sample_output = window_level;

  // half-rate toggle, forced low on every standby to normal change

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      mode_prev_reg <= 1'b0;
    end else begin
      mode_prev_reg <= NORMAL_MODE_IN;
    end
  end

  assign standby_exit = NORMAL_MODE_IN & ~mode_prev_reg;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      half_rate_toggle_reg <= 1'b0;
    end else if (standby_exit) begin
      half_rate_toggle_reg <= 1'b0;
    end else if (win_close && win_state_reg == tsp_pkg::WIN_OPEN) begin
      half_rate_toggle_reg <= ~half_rate_toggle_reg;
    end
  end

  // data-written flags: a write in the clearing cycle wins

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      wr_a_reg <= 1'b0;
    end else if (DATA_A_WRITTEN_IN) begin
      wr_a_reg <= 1'b1;
    end else if (SAMPLE_START_IN) begin
      wr_a_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      wr_b_reg <= 1'b0;
    end else if (DATA_B_WRITTEN_IN) begin
      wr_b_reg <= 1'b1;
    end else if (SAMPLE_START_IN) begin
      wr_b_reg <= 1'b0;
    end
  end

  // source selection

  assign legacy_mode = (pif.sel[0] == '0) && (pif.sel[1] == '0);

  function automatic logic src_level(input logic [tsp_pkg::SEL_W-1:0] code,
                                     input logic                      irq,
                                     input logic                      win,
                                     input logic                      led_a,
                                     input logic                      led_b,
                                     input logic                      wr_a,
                                     input logic                      wr_b,
                                     input logic                      half,
                                     input logic                      osc);
    logic lvl;
    lvl = 1'b0;
    case (code)
      tsp_pkg::SRC_IRQ:    lvl = irq;
      tsp_pkg::SRC_WINDOW: lvl = win;
      tsp_pkg::SRC_LED_A:  lvl = led_a;
      tsp_pkg::SRC_LED_B:  lvl = led_b;
      tsp_pkg::SRC_LED_AB: lvl = led_a | led_b;
      tsp_pkg::SRC_WR_A:   lvl = wr_a;
      tsp_pkg::SRC_WR_B:   lvl = wr_b;
      tsp_pkg::SRC_WR_AB:  lvl = wr_a | wr_b;
      tsp_pkg::SRC_HALF:   lvl = half;
      tsp_pkg::SRC_LOW:    lvl = 1'b0;
      tsp_pkg::SRC_HIGH:   lvl = 1'b1;
      tsp_pkg::SRC_OSC:    lvl = osc;
      default:             lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // interrupt level arrives already gated by the mask held elsewhere
  generate
    for (genvar p = 0; p < tsp_pkg::NUM_PINS; p++) begin : g_pin
      always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
          pif.asserted[p] <= 1'b0;
        end else if (legacy_mode) begin
          pif.asserted[p] <= (p == 0) ? IRQ_LEVEL_IN : legacy_sample_output;
        end else begin
          pif.asserted[p] <= src_level(pif.sel[p], IRQ_LEVEL_IN, window_level,
                                       LED_A_PULSE_IN, LED_B_PULSE_IN,
                                       wr_a_reg, wr_b_reg,
                                       half_rate_toggle_reg, OSC_32K_IN);
        end
      end

      tsp_pin_drv #(
        .PIN (p)
      ) u_drv (
        .clk_in   (CLOCK_IN),
        .rst_in   (RESET_IN),
        .pif      (pif.drv),
        .pin_out  (pin_level[p]),
        .oe_n_out (pin_oe_n[p])
      );
    end
  endgenerate

  assign TIMING_PIN_ZERO_OUT      = pin_level[0];
  assign TIMING_PIN_ZERO_OE_N_OUT = pin_oe_n[0];
  assign TIMING_PIN_ONE_OUT       = pin_level[1];
  assign TIMING_PIN_ONE_OE_N_OUT  = pin_oe_n[1];

endmodule // tsp_timing_pin_mux
`default_nettype wire

// ===== test/tsp_timing_pin_mux_properties.sv
// tsp_timing_pin_mux_properties: pin and register port checks for the timing pin mux.
// Assumes it is bound to tsp_timing_pin_mux and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module tsp_timing_pin_mux_properties (
  input wire logic        CLOCK_IN,
  input wire logic        RESET_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic        REG_RVALID_OUT,
  input wire logic        IRQ_LEVEL_IN,
  input wire logic        LED_A_PULSE_IN,
  input wire logic        LED_B_PULSE_IN,
  input wire logic        OSC_32K_IN,
  input wire logic        TIMING_PIN_ZERO_OUT,
  input wire logic        TIMING_PIN_ZERO_OE_N_OUT,
  input wire logic        TIMING_PIN_ONE_OUT
);
  logic [15:0] ctrl_reg;
  logic [15:0] sel_reg;
  logic [2:0]  age_reg;
  logic        ok;
  // shadow of written settings; age counts edges since the last write
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      ctrl_reg <= 16'h0000;
      sel_reg  <= 16'h0000;
    end else if (REG_WR_IN && REG_ADDR_IN == tsp_pkg::ADDR_PIN_CTRL) begin
      ctrl_reg <= REG_WDATA_IN & 16'h0307;
    end else if (REG_WR_IN && REG_ADDR_IN == tsp_pkg::ADDR_SRC_SEL) begin
      sel_reg <= REG_WDATA_IN & 16'h1F1F;
    end
  end
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN || REG_WR_IN) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  assign ok = (age_reg >= 3'h3);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  property p_en0_off; ok && !ctrl_reg[2] |-> TIMING_PIN_ZERO_OE_N_OUT; endproperty
  a_en0_off: assert property (p_en0_off) else $error("pin zero driven while disabled");
  property p_od0; ok && ctrl_reg[2] && ctrl_reg[1] |-> TIMING_PIN_ZERO_OE_N_OUT == (TIMING_PIN_ZERO_OUT == ctrl_reg[0]);
  endproperty
  a_od0: assert property (p_od0) else $error("open drain pin zero driven while idle");
  property p_low0; ok && sel_reg[4:0] == tsp_pkg::SRC_LOW |-> TIMING_PIN_ZERO_OUT == ctrl_reg[0]; endproperty
  a_low0: assert property (p_low0) else $error("pin zero not at low level");
  property p_high1; ok && sel_reg[12:8] == tsp_pkg::SRC_HIGH |-> TIMING_PIN_ONE_OUT != ctrl_reg[8]; endproperty
  a_high1: assert property (p_high1) else $error("pin one not at high level");
  property p_irq0;
    (ok && sel_reg[4:0] == tsp_pkg::SRC_IRQ)[*3] |-> TIMING_PIN_ZERO_OUT == ($past(IRQ_LEVEL_IN, 2) ^ ctrl_reg[0]);
  endproperty
  a_irq0: assert property (p_irq0) else $error("pin zero does not follow interrupt");
  property p_legacy; (ok && sel_reg == 16'h0000)[*3] |-> TIMING_PIN_ZERO_OUT == ($past(IRQ_LEVEL_IN, 2) ^ ctrl_reg[0]);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy pin zero not interrupt");
  property p_led0;
    (ok && sel_reg[4:0] == tsp_pkg::SRC_LED_AB)[*3]
      |-> TIMING_PIN_ZERO_OUT == (($past(LED_A_PULSE_IN, 2) | $past(LED_B_PULSE_IN, 2)) ^ ctrl_reg[0]);
  endproperty
  a_led0: assert property (p_led0) else $error("pin zero not a copy of both pulses");
  property p_osc1; (ok && sel_reg[12:8] == tsp_pkg::SRC_OSC)[*3] |-> TIMING_PIN_ONE_OUT == ($past(OSC_32K_IN, 2) ^ ctrl_reg[8]);
  endproperty
  a_osc1: assert property (p_osc1) else $error("pin one not a copy of oscillator");
  property p_rd_sel; REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == tsp_pkg::ADDR_SRC_SEL
    |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(sel_reg); endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("select readback wrong");
endmodule // tsp_timing_pin_mux_properties
`default_nettype wire

// ===== test/tsp_pin_host.sv
// tsp_pin_host: far-side logic on the two timing pins, each with a pull-up.
// Assumes the pad drives the pin level while its active-low enable is low.
`timescale 1ns/100ps
`default_nettype none
module tsp_pin_host (
  input  wire logic pin0_in,
  input  wire logic oe0_n_in,
  input  wire logic pin1_in,
  input  wire logic oe1_n_in,
  output wire logic lvl0_out,
  output wire logic lvl1_out
);
  // a released pin floats up to the pull-up level
  assign lvl0_out = oe0_n_in ? 1'b1 : pin0_in;
  assign lvl1_out = oe1_n_in ? 1'b1 : pin1_in;
endmodule // tsp_pin_host
`default_nettype wire

// ===== test/tsp_timing_pin_mux_tb_top.sv
// tsp_timing_pin_mux_tb_top: self-checking bench for the timing pin mux.
// Assumes the design, its package, the pin host model and the checker.
`timescale 1ns/100ps
`default_nettype none
module tsp_timing_pin_mux_tb_top;
  typedef struct packed {logic [15:0] c; logic [15:0] s; logic [2:0] i; logic [1:0] e;} tsp_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  // ev: 0 irq, 1 normal, 2/3 slot en, 4..7 slot start/end, 8 sample, 9/10 written, 11/12 led, 13 osc
  logic [13:0] ev = 14'h0000;
  logic [15:0] rdata;
  logic        rvalid, p0, n0, p1, n1, l0, l1;
  int          n_mismatch = 0;
  int          checks_done = 0;
  tsp_row_t    rows [12];
  always #10 clk = ~clk;
  tsp_timing_pin_mux dut (
    .CLOCK_IN(clk), .RESET_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .IRQ_LEVEL_IN(ev[0]), .NORMAL_MODE_IN(ev[1]),
    .SLOT_A_EN_IN(ev[2]), .SLOT_B_EN_IN(ev[3]), .SLOT_A_START_IN(ev[4]), .SLOT_A_END_IN(ev[5]),
    .SLOT_B_START_IN(ev[6]), .SLOT_B_END_IN(ev[7]), .SAMPLE_START_IN(ev[8]), .DATA_A_WRITTEN_IN(ev[9]),
    .DATA_B_WRITTEN_IN(ev[10]), .LED_A_PULSE_IN(ev[11]), .LED_B_PULSE_IN(ev[12]), .OSC_32K_IN(ev[13]),
    .TIMING_PIN_ZERO_OUT(p0), .TIMING_PIN_ZERO_OE_N_OUT(n0), .TIMING_PIN_ONE_OUT(p1), .TIMING_PIN_ONE_OE_N_OUT(n1));
  tsp_pin_host host (.pin0_in(p0), .oe0_n_in(n0), .pin1_in(p1), .oe1_n_in(n1), .lvl0_out(l0), .lvl1_out(l1));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // tasks start and end on a falling edge
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    wr = 1'b1;
    addr = a;
    wd = d;
    step(1);
    wr = 1'b0;
    step(3);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
    rd = 1'b1;
    addr = a;
    step(1);
    rd = 1'b0;
    chk("read valid", {15'h0000, rvalid}, 16'h0001);
    chk("read data", rdata, exp);
    step(1);
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    step(1);
    ev[i] = 1'b0;
    step(3);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    summarize;
  end
  initial begin
    rows = '{'{16'h0004, 16'h0001, 3'h4, 2'h1}, '{16'h0005, 16'h0001, 3'h4, 2'h0}, '{16'h0006, 16'h0001, 3'h0, 2'h2},
             '{16'h0000, 16'h0011, 3'h0, 2'h3}, '{16'h0004, 16'h0010, 3'h0, 2'h0}, '{16'h0005, 16'h0011, 3'h0, 2'h0},
             '{16'h0004, 16'h0005, 3'h2, 2'h1}, '{16'h0004, 16'h0006, 3'h2, 2'h0}, '{16'h0004, 16'h0007, 3'h1, 2'h1},
             '{16'h0004, 16'h001F, 3'h7, 2'h0}, '{16'h0004, 16'h0000, 3'h4, 2'h1}, '{16'h0006, 16'h0010, 3'h0, 2'h2}};
    step(2);
    rst = 1'b0;
    chk("oe after reset", {14'h0000, n1, n0}, 16'h0003);
    rreg(tsp_pkg::ADDR_PIN_CTRL, 16'h0000);
    rreg(tsp_pkg::ADDR_PIN1_EN, 16'h0000);
    foreach (rows[k]) begin
      {ev[0], ev[11], ev[12]} = rows[k].i;
      wreg(tsp_pkg::ADDR_PIN_CTRL, rows[k].c);
      wreg(tsp_pkg::ADDR_SRC_SEL, rows[k].s);
      chk("pin zero", {14'h0000, n0, p0}, {14'h0000, rows[k].e});
    end
    wreg(tsp_pkg::ADDR_PIN1_EN, 16'h0040);
    wreg(tsp_pkg::ADDR_SRC_SEL, 16'h1100);
    chk("pin one high", {14'h0000, n1, p1}, 16'h0001);
    wreg(tsp_pkg::ADDR_PIN_CTRL, 16'h0306);
    chk("pin one active low", {14'h0000, n1, p1}, 16'h0000);
    wreg(tsp_pkg::ADDR_SRC_SEL, 16'h1000);
    chk("pin one open drain idle", {14'h0000, n1, l1}, 16'h0003);
    wreg(tsp_pkg::ADDR_PIN_CTRL, 16'h0006);
    wreg(tsp_pkg::ADDR_SRC_SEL, 16'h1300);
    ev[13] = 1'b1;
    step(3);
    chk("osc high", {15'h0000, p1}, 16'h0001);
    ev[13] = 1'b0;
    step(3);
    chk("osc low", {15'h0000, p1}, 16'h0000);
    wreg(tsp_pkg::ADDR_PIN1_EN, 16'h0000);
    chk("pin one released", {14'h0000, n1, l1}, 16'h0003);
    wreg(tsp_pkg::ADDR_SRC_SEL, 16'hFFFF);
    rreg(tsp_pkg::ADDR_SRC_SEL, 16'h1F1F);
    wreg(8'h03, 16'hFFFF);
    rreg(8'h03, 16'h0000);
    wreg(tsp_pkg::ADDR_PIN_CTRL, 16'h0004);
    ev[3:2] = 2'b11;
    wreg(tsp_pkg::ADDR_SRC_SEL, 16'h0002);
    pulse(4);
    chk("window open", {15'h0000, p0}, 16'h0001);
    pulse(5);
    chk("window mid", {15'h0000, p0}, 16'h0001);
    pulse(7);
    chk("window closed", {15'h0000, p0}, 16'h0000);
    ev[2] = 1'b0;
    pulse(4);
    chk("disabled slot start", {15'h0000, p0}, 16'h0000);
    pulse(6);
    chk("single slot open", {15'h0000, p0}, 16'h0001);
    pulse(7);
    chk("single slot closed", {15'h0000, p0}, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wreg(tsp_pkg::ADDR_SRC_SEL, 16'h000C + 16'(k));
      pulse(9);
      chk("written flag", {15'h0000, p0}, {15'h0000, k != 1});
      pulse(10);
      chk("written flag b", {15'h0000, p0}, 16'h0001);
      pulse(8);
      chk("flag cleared", {15'h0000, p0}, 16'h0000);
    end
    // a write landing with the sample start keeps the flag set
    ev[9] = 1'b1;
    ev[8] = 1'b1;
    step(1);
    ev[9] = 1'b0;
    ev[8] = 1'b0;
    step(3);
    chk("write beats clear", {15'h0000, p0}, 16'h0001);
    wreg(tsp_pkg::ADDR_SRC_SEL, 16'h000F);
    pulse(6);
    pulse(7);
    chk("half before start", {15'h0000, p0}, 16'h0001);
    ev[1] = 1'b1;
    step(3);
    chk("half start", {15'h0000, p0}, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      pulse(6);
      pulse(7);
      chk("half toggle", {15'h0000, p0}, {15'h0000, k != 1});
    end
    ev[1] = 1'b0;
    step(1);
    ev[1] = 1'b1;
    step(3);
    chk("half restart", {15'h0000, p0}, 16'h0000);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    chk("oe after second reset", {14'h0000, n1, n0}, 16'h0003);
    chk("pin zero released", {14'h0000, n0, l0}, 16'h0003);
    rreg(tsp_pkg::ADDR_SRC_SEL, 16'h0000);
    wreg(tsp_pkg::ADDR_PIN1_EN, 16'h0040);
    pulse(6);
    chk("legacy sample open", {14'h0000, n1, p1}, 16'h0001);
    pulse(7);
    chk("legacy sample closed", {14'h0000, n1, p1}, 16'h0000);
    summarize;
  end
endmodule // tsp_timing_pin_mux_tb_top
bind tsp_timing_pin_mux tsp_timing_pin_mux_properties u_props (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .IRQ_LEVEL_IN(IRQ_LEVEL_IN), .LED_A_PULSE_IN(LED_A_PULSE_IN), .LED_B_PULSE_IN(LED_B_PULSE_IN),
  .OSC_32K_IN(OSC_32K_IN), .TIMING_PIN_ZERO_OUT(TIMING_PIN_ZERO_OUT),
  .TIMING_PIN_ZERO_OE_N_OUT(TIMING_PIN_ZERO_OE_N_OUT), .TIMING_PIN_ONE_OUT(TIMING_PIN_ONE_OUT));
`default_nettype wire
